// ---- verilog/legacy_port_config_bank.v ----
`timescale 1ns/1ps
`default_nettype none
`include "legacy_port_map.vh"

module legacy_port_config_bank (
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Voltage-ID pins
  input  wire [5:0]  voltage_id_in_pins,
  output reg  [5:0]  voltage_id_out_pins,
  // Host I/O decode
  input  wire [15:0] io_addr,
  input  wire        io_strobe,
  output wire        game_port_hit,
  output wire        infrared_hit,
  output wire        music_port_hit,
  // Device controls
  output reg         game_port_enable,
  output reg         infrared_enable,
  output reg         music_port_enable,
  output reg  [3:0]  infrared_irq_number,
  output reg         infrared_irq_request_enable,
  output reg         infrared_irq_invalid,
  output reg         infrared_irq_shared,
  output reg  [3:0]  music_irq_number,
  output reg         music_irq_request_enable,
  output reg         music_irq_invalid,
  output reg         music_irq_shared,
  output reg  [5:0]  music_in_location,
  output reg  [5:0]  music_out_location,
  output reg         music_locations_valid,
  output reg         music_fifo_enable,
  output reg  [3:0]  music_rx_trigger_bytes,
  output reg  [3:0]  dma_channel_select,
  output reg         dma_code_invalid
);

  // ==========================================================
  // Decode functions
  // ==========================================================

  // Interrupt level code that is not invalid; the no-line code 0 also passes
  function irq_code_ok;
    input [3:0] code;
    begin
      irq_code_ok = (code != `IRQ_BAD_LOW) && (code < `IRQ_BAD_MIN);
    end
  endfunction

  // A pin location code names a real pin group
  function location_ok;
    input [5:0] code;
    begin
      location_ok = (code[5:3] >= `LOC_GROUP_MIN) && (code[5:3] <= `LOC_GROUP_MAX);
    end
  endfunction

  // Four-way choice of pin location
  function [5:0] pick_location;
    input [1:0] sel;
    input [5:0] loc0;
    input [5:0] loc1;
    input [5:0] loc2;
    input [5:0] loc3;
    begin
      case (sel)
        2'h0:    pick_location = loc0;
        2'h1:    pick_location = loc1;
        2'h2:    pick_location = loc2;
        default: pick_location = loc3;
      endcase
    end
  endfunction

  // ==========================================================
  // Register storage
  // ==========================================================
  reg        game_active;
  reg        ir_active;
  reg        music_active;
  reg [3:0]  game_base_high;
  reg [7:0]  game_base_low;
  reg [3:0]  ir_base_high;
  reg [7:3]  ir_base_low;
  reg [3:0]  music_base_high;
  reg [7:3]  music_base_low;
  reg [3:0]  infrared_irq_level;
  reg [3:0]  music_port_irq_level;
  reg        infrared_special_config;
  reg [7:0]  music_port_special_config;
  reg [6:0]  voltage_id_output_control;
  reg [2:0]  dma_probe;
  localparam [15:0] GAME_BASE  = `GAME_BASE_RESET;
  localparam [15:0] IR_BASE    = `IR_BASE_RESET;
  localparam [15:0] MUSIC_BASE = `MUSIC_BASE_RESET;

  // ==========================================================
  // AHB-Lite address phase capture
  // ==========================================================
  reg        wr_pending;
  reg [1:0]  wr_page;
  reg [7:0]  wr_index;
  wire       addr_phase;
  wire [1:0] ap_page;
  wire [7:0] ap_index;
  reg  [7:0] read_value;

  // Single-cycle slave: never stretches, never errors
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign ap_page    = haddr[`PAGE_HI:`PAGE_LO];
  assign ap_index   = haddr[`INDEX_HI:`INDEX_LO];

  // Write data arrives one cycle after its address
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_page    <= 2'h0;
      wr_index   <= 8'h00;
    end else if (hready) begin
      wr_pending <= addr_phase & hwrite;
      wr_page    <= ap_page;
      wr_index   <= ap_index;
    end
  end

  // ==========================================================
  // Read mux, also the register view of masked bits
  // ==========================================================
  always @* begin
    read_value = 8'h00;
    if (ap_page == `PAGE_GLOBAL) begin
      if (ap_index == `IDX_VID_IN) begin
        read_value = {2'b00, voltage_id_in_pins};
      end else if (ap_index == `IDX_VID_OUT) begin
        read_value = {voltage_id_output_control[6], 1'b0, voltage_id_output_control[5:0]};
      end else if (ap_index == `IDX_DMA_PROBE) begin
        read_value = {5'h00, dma_probe};
      end else if (ap_index == `IDX_DECODE_STATUS) begin
        read_value = {4'h0, music_locations_valid, dma_code_invalid,
                      music_irq_invalid, infrared_irq_invalid};
      end
    end else if (ap_page == `PAGE_GAME) begin
      if (ap_index == `IDX_ACTIVATE) begin
        read_value = {7'h00, game_active};
      end else if (ap_index == `IDX_BASE_HIGH) begin
        read_value = {4'h0, game_base_high};
      end else if (ap_index == `IDX_BASE_LOW) begin
        read_value = game_base_low;
      end
    end else if (ap_page == `PAGE_INFRARED) begin
      if (ap_index == `IDX_ACTIVATE) begin
        read_value = {7'h00, ir_active};
      end else if (ap_index == `IDX_BASE_HIGH) begin
        read_value = {4'h0, ir_base_high};
      end else if (ap_index == `IDX_BASE_LOW) begin
        read_value = {ir_base_low, 3'b000};
      end else if (ap_index == `IDX_IRQ_LEVEL) begin
        read_value = {4'h0, infrared_irq_level};
      end else if (ap_index == `IDX_SPECIAL) begin
        read_value = {7'h00, infrared_special_config};
      end
    end else begin
      if (ap_index == `IDX_ACTIVATE) begin
        read_value = {7'h00, music_active};
      end else if (ap_index == `IDX_BASE_HIGH) begin
        read_value = {4'h0, music_base_high};
      end else if (ap_index == `IDX_BASE_LOW) begin
        read_value = {music_base_low, 3'b000};
      end else if (ap_index == `IDX_IRQ_LEVEL) begin
        read_value = {4'h0, music_port_irq_level};
      end else if (ap_index == `IDX_SPECIAL) begin
        read_value = music_port_special_config;
      end
    end
  end

  // Read data sampled at the address edge, held through the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= {24'h000000, read_value};
    end
  end

  // ==========================================================
  // Register writes in the data phase
  // ==========================================================
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      game_active               <= 1'b0;
      ir_active                 <= 1'b0;
      music_active              <= 1'b0;
      game_base_high            <= GAME_BASE[11:8];
      game_base_low             <= GAME_BASE[7:0];
      ir_base_high              <= IR_BASE[11:8];
      ir_base_low               <= IR_BASE[7:3];
      music_base_high           <= MUSIC_BASE[11:8];
      music_base_low            <= MUSIC_BASE[7:3];
      infrared_irq_level        <= `IR_IRQ_RESET;
      music_port_irq_level      <= `MUSIC_IRQ_RESET;
      infrared_special_config   <= 1'b0;
      music_port_special_config <= `SPECIAL_RESET;
      voltage_id_output_control <= `VID_OUT_RESET;
      dma_probe                 <= `DMA_PROBE_RESET;
    end else if (wr_pending) begin
      if (wr_page == `PAGE_GLOBAL) begin
        if (wr_index == `IDX_VID_OUT) begin
          // Reserved bit 6 is dropped; bit 7 kept as select
          voltage_id_output_control <= {hwdata[`VID_SEL_BIT], hwdata[5:0]};
        end else if (wr_index == `IDX_DMA_PROBE) begin
          dma_probe <= hwdata[2:0];
        end
      end else if (wr_page == `PAGE_GAME) begin
        if (wr_index == `IDX_ACTIVATE) begin
          game_active <= hwdata[`ACT_BIT];
        end else if (wr_index == `IDX_BASE_HIGH) begin
          game_base_high <= hwdata[3:0];
        end else if (wr_index == `IDX_BASE_LOW) begin
          game_base_low <= hwdata[7:0];
        end
      end else if (wr_page == `PAGE_INFRARED) begin
        if (wr_index == `IDX_ACTIVATE) begin
          ir_active <= hwdata[`ACT_BIT];
        end else if (wr_index == `IDX_BASE_HIGH) begin
          ir_base_high <= hwdata[3:0];
        end else if (wr_index == `IDX_BASE_LOW) begin
          ir_base_low <= hwdata[7:3];
        end else if (wr_index == `IDX_IRQ_LEVEL) begin
          infrared_irq_level <= hwdata[3:0];
        end else if (wr_index == `IDX_SPECIAL) begin
          infrared_special_config <= hwdata[`IR_SHARE_BIT];
        end
      end else begin
        if (wr_index == `IDX_ACTIVATE) begin
          music_active <= hwdata[`ACT_BIT];
        end else if (wr_index == `IDX_BASE_HIGH) begin
          music_base_high <= hwdata[3:0];
        end else if (wr_index == `IDX_BASE_LOW) begin
          music_base_low <= hwdata[7:3];
        end else if (wr_index == `IDX_IRQ_LEVEL) begin
          music_port_irq_level <= hwdata[3:0];
        end else if (wr_index == `IDX_SPECIAL) begin
          music_port_special_config <= hwdata[7:0];
        end
      end
    end
  end

  // ==========================================================
  // Voltage-ID output path
  // ==========================================================

  // Registered so the pins never glitch on a select change
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      voltage_id_out_pins <= 6'h00;
    end else if (voltage_id_output_control[6]) begin
      voltage_id_out_pins <= voltage_id_output_control[5:0];
    end else begin
      voltage_id_out_pins <= voltage_id_in_pins;
    end
  end

  // ==========================================================
  // Decoded device controls
  // ==========================================================
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      game_port_enable            <= 1'b0;
      infrared_enable             <= 1'b0;
      music_port_enable           <= 1'b0;
      infrared_irq_number         <= 4'h0;
      infrared_irq_request_enable <= 1'b0;
      infrared_irq_invalid        <= 1'b0;
      infrared_irq_shared         <= 1'b0;
      music_irq_number            <= 4'h0;
      music_irq_request_enable    <= 1'b0;
      music_irq_invalid           <= 1'b0;
      music_irq_shared            <= 1'b0;
    end else begin
      game_port_enable            <= game_active;
      infrared_enable             <= ir_active;
      music_port_enable           <= music_active;
      // An invalid code is treated as no line at all
      infrared_irq_number         <= irq_code_ok(infrared_irq_level) ? infrared_irq_level : `IRQ_NONE;
      infrared_irq_request_enable <= ir_active & irq_code_ok(infrared_irq_level) &
                                     (infrared_irq_level != `IRQ_NONE);
      infrared_irq_invalid        <= ~irq_code_ok(infrared_irq_level);
      infrared_irq_shared         <= infrared_special_config;
      music_irq_number            <= irq_code_ok(music_port_irq_level) ? music_port_irq_level : `IRQ_NONE;
      music_irq_request_enable    <= music_active & irq_code_ok(music_port_irq_level) &
                                     (music_port_irq_level != `IRQ_NONE);
      music_irq_invalid           <= ~irq_code_ok(music_port_irq_level);
      music_irq_shared            <= music_port_special_config[`MSC_SHARE_BIT];
    end
  end

  // ==========================================================
  // Music port pins, FIFO and DMA code
  // ==========================================================
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      music_in_location      <= `LOC_IN_0;
      music_out_location     <= `LOC_OUT_0;
      music_locations_valid  <= 1'b1;
      music_fifo_enable      <= 1'b1;
      music_rx_trigger_bytes <= `TRIG_BYTES_0;
      dma_channel_select     <= 4'h0;
      dma_code_invalid       <= 1'b0;
    end else begin
      music_in_location <= pick_location(music_port_special_config[`MSC_IN_HI:`MSC_IN_LO],
                                         `LOC_IN_0, `LOC_IN_1, `LOC_IN_2, `LOC_IN_3);
      music_out_location <= pick_location(music_port_special_config[`MSC_OUT_HI:`MSC_OUT_LO],
                                          `LOC_OUT_0, `LOC_OUT_1, `LOC_OUT_2, `LOC_OUT_3);
      music_locations_valid <= location_ok(music_in_location) & location_ok(music_out_location);
      music_fifo_enable <= ~music_port_special_config[`MSC_FIFO_DIS_BIT];
      case (music_port_special_config[`MSC_TRIG_HI:`MSC_TRIG_LO])
        2'h0:    music_rx_trigger_bytes <= `TRIG_BYTES_0;
        2'h1:    music_rx_trigger_bytes <= `TRIG_BYTES_1;
        2'h2:    music_rx_trigger_bytes <= `TRIG_BYTES_2;
        default: music_rx_trigger_bytes <= `TRIG_BYTES_3;
      endcase
      // One-hot channel; none for the no-channel and invalid codes
      if (dma_probe < `DMA_NONE) begin
        dma_channel_select <= 4'h1 << dma_probe[1:0];
      end else begin
        dma_channel_select <= 4'h0;
      end
      dma_code_invalid <= (dma_probe >= `DMA_BAD_MIN);
    end
  end

  // ==========================================================
  // Host I/O window decode
  // ==========================================================
  wire [47:0] base_vec;
  wire [2:0]  active_vec;
  wire [2:0]  hit_vec;

  assign base_vec   = {4'h0, music_base_high, music_base_low, 3'b000,
                       4'h0, ir_base_high, ir_base_low, 3'b000,
                       4'h0, game_base_high, game_base_low};
  assign active_vec = {music_active, ir_active, game_active};

  genvar dev;
  generate
    for (dev = 0; dev < 3; dev = dev + 1) begin : g_window
      io_window_match #(
        .ALIGN_BITS ((dev == 0) ? `GAME_ALIGN : `WIDE_ALIGN)
      ) u_match (
        .base      (base_vec[dev*16 +: 16]),
        .active    (active_vec[dev]),
        .io_addr   (io_addr),
        .io_strobe (io_strobe),
        .hit       (hit_vec[dev])
      );
    end
  endgenerate

  // Hits are combinational so a host cycle is claimed in its own cycle
  assign game_port_hit  = hit_vec[0];
  assign infrared_hit   = hit_vec[1];
  assign music_port_hit = hit_vec[2];

endmodule // legacy_port_config_bank

`default_nettype wire

// ---- verilog/legacy_port_map.vh ----
`ifndef LEGACY_PORT_MAP_VH
`define LEGACY_PORT_MAP_VH

// ==========================================================
// Bus address layout: byte address = page * 0x400 + 4 * index
// ==========================================================
`define PAGE_GLOBAL        2'h0
`define PAGE_GAME          2'h1
`define PAGE_INFRARED      2'h2
`define PAGE_MUSIC         2'h3
`define PAGE_HI            11
`define PAGE_LO            10
`define INDEX_HI           9
`define INDEX_LO           2

// ==========================================================
// Register indices
// ==========================================================
`define IDX_ACTIVATE       8'h30
`define IDX_BASE_HIGH      8'h60
`define IDX_BASE_LOW       8'h61
`define IDX_IRQ_LEVEL      8'h70
`define IDX_SPECIAL        8'hF0
`define IDX_VID_IN         8'hFE
`define IDX_VID_OUT        8'hFF
`define IDX_DMA_PROBE      8'h02
`define IDX_DECODE_STATUS  8'h03

// ==========================================================
// Reset values
// ==========================================================
`define GAME_BASE_RESET    16'h0201
`define IR_BASE_RESET      16'h0310
`define MUSIC_BASE_RESET   16'h0300
`define IR_IRQ_RESET       4'hB
`define MUSIC_IRQ_RESET    4'hA
`define SPECIAL_RESET      8'h00
`define VID_OUT_RESET      7'h00
`define DMA_PROBE_RESET    3'h4

// ==========================================================
// Field positions
// ==========================================================
`define ACT_BIT            0
`define VID_SEL_BIT        7
`define IR_SHARE_BIT       0
`define MSC_IN_HI          7
`define MSC_IN_LO          6
`define MSC_OUT_HI         5
`define MSC_OUT_LO         4
`define MSC_FIFO_DIS_BIT   3
`define MSC_TRIG_HI        2
`define MSC_TRIG_LO        1
`define MSC_SHARE_BIT      0

// ==========================================================
// Codes
// ==========================================================
`define IRQ_NONE           4'h0
`define IRQ_BAD_LOW        4'h2
`define IRQ_BAD_MIN        4'hD
`define DMA_NONE           3'h4
`define DMA_BAD_MIN        3'h5
`define LOC_GROUP_MIN      3'h1
`define LOC_GROUP_MAX      3'h6
`define LOC_IN_0           6'h37
`define LOC_IN_1           6'h31
`define LOC_IN_2           6'h2E
`define LOC_IN_3           6'h08
`define LOC_OUT_0          6'h36
`define LOC_OUT_1          6'h30
`define LOC_OUT_2          6'h2D
`define LOC_OUT_3          6'h09
`define TRIG_BYTES_0       4'h1
`define TRIG_BYTES_1       4'h4
`define TRIG_BYTES_2       4'h8
`define TRIG_BYTES_3       4'hE
`define GAME_ALIGN         0
`define WIDE_ALIGN         3

`endif

// ---- verilog/io_window_match.v ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Base address window compare for one logical device
// ==========================================================
module io_window_match #(
  parameter ALIGN_BITS = 0
) (
  input  wire [15:0] base,
  input  wire        active,
  input  wire [15:0] io_addr,
  input  wire        io_strobe,
  output wire        hit
);

  // Address bits below the alignment are don't-care inside the window
  localparam [15:0] MASK = ~((16'h0001 << ALIGN_BITS) - 16'h0001);

  // No answer at all while the device is switched off
  assign hit = active & io_strobe & (((io_addr ^ base) & MASK) == 16'h0000);

endmodule // io_window_match

`default_nettype wire

// ---- tb/legacy_port_config_bank_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port-level checks of the configuration bank
// ==========================================================
module legacy_port_config_bank_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        io_strobe,
  input wire logic        game_port_hit,
  input wire logic        infrared_hit,
  input wire logic        music_port_hit,
  input wire logic [3:0]  infrared_irq_number,
  input wire logic        infrared_irq_invalid,
  input wire logic [3:0]  music_irq_number,
  input wire logic        music_irq_request_enable,
  input wire logic        music_irq_invalid,
  input wire logic [5:0]  music_in_location,
  input wire logic        music_locations_valid,
  input wire logic [3:0]  music_rx_trigger_bytes,
  input wire logic [3:0]  dma_channel_select,
  input wire logic        dma_code_invalid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus never stalls and never errors
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  // Hits only exist while the host strobes
  chk_hit_strobe: assert property ((game_port_hit || infrared_hit || music_port_hit) |-> io_strobe)
    else $error("hit without strobe");
  chk_irq_request: assert property (music_irq_request_enable |-> music_irq_number != 4'h0 && !music_irq_invalid)
    else $error("request with bad level");
  chk_music_invalid: assert property (music_irq_invalid |-> music_irq_number == 4'h0)
    else $error("invalid level passed on");
  chk_ir_invalid: assert property (infrared_irq_invalid |-> infrared_irq_number == 4'h0)
    else $error("invalid ir level passed on");
  chk_trig_codes: assert property (music_rx_trigger_bytes inside {4'h1, 4'h4, 4'h8, 4'hE})
    else $error("bad trigger level");
  chk_dma_select: assert property ($onehot0(dma_channel_select) && (!dma_code_invalid || dma_channel_select == 4'h0))
    else $error("bad dma select");
  chk_loc_group: assert property (music_in_location[5:3] inside {3'h1, 3'h5, 3'h6} |=> music_locations_valid)
    else $error("location marked invalid");

  cover property (game_port_hit);
  cover property (music_irq_invalid);
  cover property (dma_code_invalid);
endmodule // legacy_port_config_bank_properties

bind legacy_port_config_bank legacy_port_config_bank_properties chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .io_strobe(io_strobe), .game_port_hit(game_port_hit), .infrared_hit(infrared_hit),
  .music_port_hit(music_port_hit), .infrared_irq_number(infrared_irq_number),
  .infrared_irq_invalid(infrared_irq_invalid), .music_irq_number(music_irq_number),
  .music_irq_request_enable(music_irq_request_enable), .music_irq_invalid(music_irq_invalid),
  .music_in_location(music_in_location), .music_locations_valid(music_locations_valid),
  .music_rx_trigger_bytes(music_rx_trigger_bytes), .dma_channel_select(dma_channel_select),
  .dma_code_invalid(dma_code_invalid));

`default_nettype wire

// ---- tb/tb_legacy_port_config_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_legacy_port_config_bank;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [5:0]  vin = 6'h00;
  logic [15:0] io_addr = 16'h0;
  logic        io_strobe = 1'b0;
  wire         hreadyout, hresp, gh, ih, mh, ge, ie, me, iq_re, iq_inv, iq_sh, mq_re, mq_inv, mq_sh;
  wire         loc_ok, fifo_en, dma_inv;
  wire  [31:0] hrdata;
  wire  [5:0]  vout, lin, lout;
  wire  [3:0]  iq_n, mq_n, trig, dma_sel;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [31:0] rd;

  // ==========================================================
  // Clock, design and hang guard
  // ==========================================================
  always #10 hclk = ~hclk;

  legacy_port_config_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .voltage_id_in_pins(vin), .voltage_id_out_pins(vout), .io_addr(io_addr),
    .io_strobe(io_strobe), .game_port_hit(gh), .infrared_hit(ih), .music_port_hit(mh),
    .game_port_enable(ge), .infrared_enable(ie), .music_port_enable(me), .infrared_irq_number(iq_n),
    .infrared_irq_request_enable(iq_re), .infrared_irq_invalid(iq_inv), .infrared_irq_shared(iq_sh),
    .music_irq_number(mq_n), .music_irq_request_enable(mq_re), .music_irq_invalid(mq_inv),
    .music_irq_shared(mq_sh), .music_in_location(lin), .music_out_location(lout),
    .music_locations_valid(loc_ok), .music_fifo_enable(fifo_en), .music_rx_trigger_bytes(trig),
    .dma_channel_select(dma_sel), .dma_code_invalid(dma_inv));

  // Cycle ceiling well above the few hundred the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for hready at a rising edge, however long the slave takes
  task automatic wt();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // One single transfer: address phase, then data phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask

  // Stored value reaches the outputs one cycle after the store
  task automatic st();
    repeat (2) @(posedge hclk);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  logic [31:0] ra[16] = '{32'h4C0, 32'h580, 32'h584, 32'h8C0, 32'h980, 32'h984, 32'h9C0, 32'hBC0,
                          32'hCC0, 32'hD80, 32'hD84, 32'hDC0, 32'hFC0, 32'h3FC, 32'h008, 32'h010};
  logic [7:0]  rv[16] = '{8'h00, 8'h02, 8'h01, 8'h00, 8'h03, 8'h10, 8'h0B, 8'h00,
                          8'h00, 8'h03, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h04, 8'h00};
  logic [7:0]  wm[16] = '{8'h01, 8'h0F, 8'hFF, 8'h01, 8'h0F, 8'hF8, 8'h0F, 8'h01,
                          8'h01, 8'h0F, 8'hF8, 8'h0F, 8'hFF, 8'hBF, 8'h07, 8'h00};

  // Reset values, then writable masks with an unmapped word at the end
  task automatic t_regs(input bit wr);
    for (int i = 0; i < 16; i++) begin
      if (!wr) begin
        bus(ra[i], 1'b0, 32'h0);
        chk(rd, {24'h0, rv[i]});
      end else begin
        bus(ra[i], 1'b1, 32'hFFFF_FFFF);
        bus(ra[i], 1'b0, 32'h0);
        chk(rd, {24'h0, wm[i]});
        bus(ra[i], 1'b1, 32'h0);
      end
    end
  endtask

  task automatic t_vid();
    vin <= 6'h15;
    st();
    chk(vout, 6'h15);
    bus(32'h3F8, 1'b0, 32'h0);
    chk(rd, 32'h15);
    bus(32'h3FC, 1'b1, 32'h8C);
    vin <= 6'h33;
    st();
    chk(vout, 6'h0C);
    bus(32'h3FC, 1'b1, 32'h00);
    st();
    chk(vout, 6'h33);
  endtask

  task automatic io(input logic [15:0] a, input logic s, input logic [2:0] e);
    io_addr <= a;
    io_strobe <= s;
    @(posedge hclk);
    chk({gh, ih, mh}, e);
  endtask

  task automatic t_decode();
    io(16'h0201, 1'b1, 3'b000);
    bus(32'h4C0, 1'b1, 32'h1);
    bus(32'h8C0, 1'b1, 32'h1);
    st();
    chk({ge, ie, me}, 3'b110);
    io(16'h0201, 1'b1, 3'b100);
    io(16'h0201, 1'b0, 3'b000);
    io(16'h0200, 1'b1, 3'b000);
    io(16'h0317, 1'b1, 3'b010);
    io(16'h0318, 1'b1, 3'b000);
    io(16'h0300, 1'b1, 3'b000);
    io_strobe <= 1'b0;
  endtask

  // Every level code on both devices, music active and infrared not
  task automatic t_irq();
    bit inv;
    bus(32'hCC0, 1'b1, 32'h1);
    for (int c = 0; c < 16; c++) begin
      inv = (c == 2) || (c >= 13);
      bus(32'hDC0, 1'b1, c);
      bus(32'h9C0, 1'b1, c);
      st();
      chk({mq_inv, mq_n, mq_re}, {inv, inv ? 4'h0 : 4'(c), !inv && c != 0});
      chk({iq_inv, iq_n, iq_re}, {inv, inv ? 4'h0 : 4'(c), 1'b0});
    end
  endtask

  task automatic t_music();
    logic [5:0] li[4] = '{6'h37, 6'h31, 6'h2E, 6'h08};
    logic [5:0] lo[4] = '{6'h36, 6'h30, 6'h2D, 6'h09};
    logic [3:0] tg[4] = '{4'h1, 4'h4, 4'h8, 4'hE};
    for (int i = 0; i < 4; i++) begin
      bus(32'hFC0, 1'b1, {24'h0, 2'(i), 2'(i), i[0], 2'(i), i[1]});
      bus(32'hBC0, 1'b1, {31'h0, i[0]});
      st();
      @(posedge hclk);
      chk({lin, lout, loc_ok}, {li[i], lo[i], 1'b1});
      chk({fifo_en, trig, mq_sh, iq_sh}, {!i[0], tg[i], i[1], i[0]});
    end
  endtask

  task automatic t_dma();
    for (int c = 0; c < 8; c++) begin
      bus(32'h008, 1'b1, c);
      st();
      chk({dma_inv, dma_sel}, {c > 4, c < 4 ? 4'h1 << c : 4'h0});
      bus(32'h00C, 1'b0, 32'h0);
      chk(rd[3:2], {1'b1, c > 4});
    end
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs(1'b0);
    t_vid();
    t_decode();
    t_regs(1'b1);
    t_irq();
    t_music();
    t_dma();
    end_sim();
  end
endmodule // tb_legacy_port_config_bank

`default_nettype wire
